// *** common/scpc_pkg.sv ***
package scpc_pkg;
	typedef enum logic [1:0] {
		SCPC_BM_WORD = 2'b00,
		SCPC_BM_HIGH = 2'b01,
		SCPC_BM_LOW  = 2'b10,
		SCPC_BM_RSVD = 2'b11
	} scpc_narrow_access_select_e;
	typedef enum logic {
		SCPC_CAP_WAIT = 1'b0,
		SCPC_CAP_DONE = 1'b1
	} scpc_cap_e;
	typedef struct packed {
		logic       core_regulator_enable_strap_n;
		logic       ref_sel;
		logic       rtc_osc_on;
		logic       core_pwr_good;
		logic [5:0] boot;
	} scpc_pins_s;
	typedef struct packed {
		logic core_regulator_enable;
		logic core_voltage_select;
		logic usb_regulator_enable;
		logic ref_from_pin;
		logic usb_osc_enable;
		logic rtc_run;
	} scpc_power_s;
	typedef struct packed {
		scpc_narrow_access_select_e extmem;
		scpc_narrow_access_select_e usb;
	} scpc_width_s;
endpackage

// *** common/scpc_regs.svh ***
`ifndef SCPC_REGS_SVH
`define SCPC_REGS_SVH
// Register indices; byte address is four times the index
`define SCPC_IDX_W        15
`define SCPC_IDX_IDLE     15'h1C01
`define SCPC_IDX_PCG1     15'h1C02
`define SCPC_IDX_PCG2     15'h1C03
`define SCPC_IDX_SRCNT    15'h1C04
`define SCPC_IDX_PRST     15'h1C05
`define SCPC_IDX_SLEW     15'h1C16
`define SCPC_IDX_PULL1    15'h1C17
`define SCPC_IDX_PULL2    15'h1C18
`define SCPC_IDX_PULL3    15'h1C19
`define SCPC_IDX_PULL4    15'h1C4C
`define SCPC_IDX_PULL5    15'h1C4D
`define SCPC_IDX_PULL6    15'h1C4F
`define SCPC_IDX_PULL7    15'h1C50
`define SCPC_IDX_USB      15'h1C32
`define SCPC_IDX_EXT      15'h1C33
`define SCPC_IDX_BOOT     15'h1C34
`define SCPC_IDX_LDO      15'h7004
`define SCPC_IDX_RTC_LO   15'h1900
`define SCPC_IDX_RTC_HI   15'h197F
// Field positions
`define SCPC_LDO_USB_EN   0
`define SCPC_LDO_VSEL     1
`define SCPC_NARROW_LSB   0
`define SCPC_USB_OSC_DIS  4
`define SCPC_USB_BIAS_DIS 5
`define SCPC_SLEW_SLOW    0
// Reset values
`define SCPC_RST_LDO      16'h0000
`define SCPC_RST_USB      16'h0030
`define SCPC_RST_EXT      16'h0000
`define SCPC_RST_PCG      16'h0000
`define SCPC_RST_PULL     16'h0000
`define SCPC_RST_IDLE     16'h0000
`define SCPC_RST_SLEW     16'h0000
`define SCPC_RST_PRST     16'h0000
// Timing: cycles from reset release to strap capture
`define SCPC_BOOT_CAPT_CYC 10
`endif

// *** hdl/scpc_top.sv ***
`include "scpc_regs.svh"
// How it works
// R01: Strap low enables core regulator; level from core_voltage_select.
// R02: Bit 1 picks 1.05 V or 1.3 V; reset gives 1.3 V.
// R03: USB regulator follows bit 0 if ref strap high, else forced on.
// R04: Accesses 16-bit after reset; 01b high byte, 10b low byte, per space.
// R05: One inhibit bit per pull resistor; most pulls on at reset. Code resets every inhibit bit to 0, so all pulls are on.
// R06: Core power off forces pulls off and bus holders on.
// R07: Slew register picks fast or slow edges for clock and memory pins.
// R08: Board ties the reference strap static; no change after reset.
// R09: Strap 0: USB oscillator clocks system and USB PLL, stays on.
// R10: Strap 1: external pin feeds system clock; USB oscillator switchable.
// R11: RTC oscillator off stops RTC and blocks 1900h to 197Fh.
// R12: Six boot straps captured into boot field at 1C34h.
// R13: Gate registers enable clocks; counter and control drive resets.
// R14: Firmware enables each clock only while probing that peripheral.
// R15: At hand-over all clocks gated, all idle domains but CPU idled.
// R16: Firmware register tweaks keep clock frequency and first timer.
// R17: Boot straps captured about 10 cycles after reset release.
// R18: Registers are 16 bits, accessed as single 16-bit words.
module scpc_top
	import scpc_pkg::*;
	#(
	parameter int ADR_W     = 17,
	parameter int BOOT_CAPT = `SCPC_BOOT_CAPT_CYC
	) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire scpc_pins_s  pins_i,
	output logic             rtc_req_o,
	input  wire logic        rtc_ack_i,
	input  wire logic [15:0] rtc_rdata_i,
	output scpc_power_s      power_o,
	output scpc_width_s      width_o,
	output logic      [111:0] pull_enable_o,
	output logic             bus_hold_o,
	output logic             slew_slow_o,
	output logic      [31:0] periph_clk_en_o,
	output logic      [15:0] idle_req_o,
	output logic      [15:0] periph_rst_o
	);

	// ****************************************
	// Parameter checks
	// ****************************************
	// Index field must fit the address bus above the byte lanes
	// Capture delay below three would read straps before the
	// synchroniser has filled after reset
	if (ADR_W < `SCPC_IDX_W + 2) begin
		$error("ADR_W too small for the register map");
	end
	if (BOOT_CAPT < 3 || BOOT_CAPT > 255) begin
		$error("BOOT_CAPT must be 3 to 255");
	end

	// ****************************************
	// Functions
	// ****************************************
	// Index of pull inhibit register k
	// The inhibit registers are not contiguous, so a lookup
	// table is used instead of index arithmetic
	function automatic logic [`SCPC_IDX_W-1:0] pull_idx(input int k);
		unique case (k)
			0: pull_idx = `SCPC_IDX_PULL1;
			1: pull_idx = `SCPC_IDX_PULL2;
			2: pull_idx = `SCPC_IDX_PULL3;
			3: pull_idx = `SCPC_IDX_PULL4;
			4: pull_idx = `SCPC_IDX_PULL5;
			5: pull_idx = `SCPC_IDX_PULL6;
			default: pull_idx = `SCPC_IDX_PULL7;
		endcase
	endfunction

	// Reserved narrow code falls back to full width
	// Shared by both spaces so their decode never drifts apart
	function automatic scpc_narrow_access_select_e narrow_mode(input logic [15:0] r);
		logic [1:0] f;
		f = r[`SCPC_NARROW_LSB +: 2];
		unique case (f)
			2'b01: narrow_mode = SCPC_BM_HIGH;
			2'b10: narrow_mode = SCPC_BM_LOW;
			default: narrow_mode = SCPC_BM_WORD;
		endcase
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	scpc_pins_s sync1_reg;
	scpc_pins_s sync2_reg;

	// Straps are asynchronous; two stages before use
	// Every pin input passes these stages, none is read raw
	// Limitation: a strap moving within two cycles of the
	// capture edge may be taken from either side of the move
	// Trade-off: no reset here, so straps keep flowing while
	// reset is held and are settled by the time it releases
	always_ff @(posedge clk_sys) begin
		sync1_reg <= pins_i;
		sync2_reg <= sync1_reg;
	end

	// ****************************************
	// Strap capture after reset release
	// ****************************************
	scpc_cap_e  cap_reg;
	scpc_cap_e  cap_next;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [5:0] boot_reg;
	logic [5:0] boot_next;
	logic       ref_reg;
	logic       ref_next;

	// Count from release, then latch once; later strap moves ignored
	// The counter freezes once the capture is done, so a long
	// run never wraps it back into the capture window
	// Boot field and reference latch hold until the next reset
	always_comb begin
		cap_next  = cap_reg;
		cnt_next  = cnt_reg;
		boot_next = boot_reg;
		ref_next  = ref_reg;
		unique case (cap_reg)
			SCPC_CAP_WAIT: begin
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == 8'(BOOT_CAPT - 1)) begin // R17
					boot_next = sync2_reg.boot; // R12
					ref_next  = sync2_reg.ref_sel; // R08
					cap_next  = SCPC_CAP_DONE;
				end
			end
			SCPC_CAP_DONE: begin
				cnt_next = cnt_reg;
			end
		endcase
	end

	// Synchronous reset restarts the capture window
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cap_reg  <= SCPC_CAP_WAIT;
			cnt_reg  <= 8'h00;
			boot_reg <= 6'h00;
			ref_reg  <= 1'b0;
		end else begin
			cap_reg  <= cap_next;
			cnt_reg  <= cnt_next;
			boot_reg <= boot_next;
			ref_reg  <= ref_next;
		end
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	logic [`SCPC_IDX_W-1:0] idx;
	logic        req;
	logic        rtc_hit;
	logic        fwd;
	logic        local_req;
	logic        wr_en;
	logic        ack_reg;
	logic        ack_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;

	// Local access: request seen on one edge, ack high for the
	// following cycle, write lands on the ack edge
	// RTC space goes to the RTC block, whose ack passes straight
	// through; its latency is whatever that block needs
	// A master may keep the strobe high between requests; acks
	// then alternate, giving one transfer every two cycles
	assign idx       = wb_adr_i[`SCPC_IDX_W+1:2];
	assign req       = wb_cyc_i && wb_stb_i;
	assign rtc_hit   = idx >= `SCPC_IDX_RTC_LO && idx <= `SCPC_IDX_RTC_HI;
	// RTC space passes through only with its oscillator running
	assign fwd       = req && rtc_hit && sync2_reg.rtc_osc_on; // R11
	assign local_req = req && !fwd;
	// Write lands on the ack edge; partial words are dropped
	// Partial writes are still acked so the master never hangs
	assign wr_en     = local_req && ack_reg && wb_we_i
		&& wb_sel_i[1:0] == 2'b11; // R18
	assign rtc_req_o = fwd;
	assign wb_ack_o  = ack_reg || (fwd && rtc_ack_i);
	assign wb_dat_o  = fwd ? {16'h0000, rtc_rdata_i}
		: {16'h0000, rdata_reg};

	// ****************************************
	// Control registers
	// ****************************************
	// All registers are full 16-bit words with no byte lanes
	// Unused bits of the writable registers are stored and read back
	// as written; the boot register ignores writes and reads zero above bit 5
	logic [15:0] ldo_reg,  ldo_next;
	logic [15:0] usb_reg,  usb_next;
	logic [15:0] ext_reg,  ext_next;
	logic [15:0] pcg1_reg, pcg1_next;
	logic [15:0] pcg2_reg, pcg2_next;
	logic [15:0] idle_reg, idle_next;
	logic [15:0] slew_reg, slew_next;
	logic [15:0] prst_reg, prst_next;
	logic [15:0] scnt_reg, scnt_next;
	logic [15:0] pull_reg  [7];
	logic [15:0] pull_next [7];

	// Ack one cycle after request; read data prepared at the same time
	// Read data is captured with the request, so the ack cycle
	// carries a registered value and no decode path reaches
	// the bus output
	// Boot field sits in the low six bits; upper bits read zero
	always_comb begin
		ack_next   = local_req && !ack_reg;
		rdata_next = rdata_reg;
		if (local_req && !ack_reg) begin
			rdata_next = 16'h0000; // RTC space with oscillator off reads 0
			unique case (idx)
				`SCPC_IDX_LDO:   rdata_next = ldo_reg;
				`SCPC_IDX_USB:   rdata_next = usb_reg;
				`SCPC_IDX_EXT:   rdata_next = ext_reg;
				`SCPC_IDX_PCG1:  rdata_next = pcg1_reg;
				`SCPC_IDX_PCG2:  rdata_next = pcg2_reg;
				`SCPC_IDX_IDLE:  rdata_next = idle_reg;
				`SCPC_IDX_SLEW:  rdata_next = slew_reg;
				`SCPC_IDX_PRST:  rdata_next = prst_reg;
				`SCPC_IDX_SRCNT: rdata_next = scnt_reg;
				`SCPC_IDX_BOOT:  rdata_next = {10'h000, boot_reg}; // R12
				default: rdata_next = 16'h0000;
			endcase
			for (int k = 0; k < 7; k++) begin
				if (idx == pull_idx(k)) begin
					rdata_next = pull_reg[k];
				end
			end
		end
	end

	// Register writes; soft reset counter runs down when not written
	// A write to the counter wins over the decrement in the same
	// cycle, so a reload never loses a count
	always_comb begin
		ldo_next  = ldo_reg;
		usb_next  = usb_reg;
		ext_next  = ext_reg;
		pcg1_next = pcg1_reg;
		pcg2_next = pcg2_reg;
		idle_next = idle_reg;
		slew_next = slew_reg;
		prst_next = prst_reg;
		scnt_next = (scnt_reg != 16'h0000) ? scnt_reg - 16'h0001
			: scnt_reg;
		for (int k = 0; k < 7; k++) begin
			pull_next[k] = pull_reg[k];
		end
		if (wr_en) begin
			unique case (idx)
				`SCPC_IDX_LDO:   ldo_next  = wb_dat_i[15:0]; // R02
				`SCPC_IDX_USB:   usb_next  = wb_dat_i[15:0]; // R04
				`SCPC_IDX_EXT:   ext_next  = wb_dat_i[15:0]; // R04
				`SCPC_IDX_PCG1:  pcg1_next = wb_dat_i[15:0]; // R13
				`SCPC_IDX_PCG2:  pcg2_next = wb_dat_i[15:0]; // R13
				`SCPC_IDX_IDLE:  idle_next = wb_dat_i[15:0]; // R15
				`SCPC_IDX_SLEW:  slew_next = wb_dat_i[15:0]; // R07
				`SCPC_IDX_PRST:  prst_next = wb_dat_i[15:0]; // R13
				`SCPC_IDX_SRCNT: scnt_next = wb_dat_i[15:0]; // R13
				default: ;
			endcase
			for (int k = 0; k < 7; k++) begin
				if (idx == pull_idx(k)) begin
					pull_next[k] = wb_dat_i[15:0]; // R05
				end
			end
		end
	end

	// Reset branch loads constants only
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 16'h0000;
			ldo_reg   <= `SCPC_RST_LDO; // R02
			usb_reg   <= `SCPC_RST_USB;
			ext_reg   <= `SCPC_RST_EXT; // R04
			pcg1_reg  <= `SCPC_RST_PCG;
			pcg2_reg  <= `SCPC_RST_PCG;
			idle_reg  <= `SCPC_RST_IDLE;
			slew_reg  <= `SCPC_RST_SLEW;
			prst_reg  <= `SCPC_RST_PRST;
			scnt_reg  <= 16'h0000;
			for (int k = 0; k < 7; k++) begin
				pull_reg[k] <= `SCPC_RST_PULL; // R05
			end
		end else begin
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
			ldo_reg   <= ldo_next;
			usb_reg   <= usb_next;
			ext_reg   <= ext_next;
			pcg1_reg  <= pcg1_next;
			pcg2_reg  <= pcg2_next;
			idle_reg  <= idle_next;
			slew_reg  <= slew_next;
			prst_reg  <= prst_next;
			scnt_reg  <= scnt_next;
			for (int k = 0; k < 7; k++) begin
				pull_reg[k] <= pull_next[k];
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic osc_off_req;

	// Reference latch low means the USB oscillator drives the
	// system clock, so its disable bits are ignored and the USB
	// regulator stays on
	// Both disable bits must clear before the oscillator may run
	assign osc_off_req = usb_reg[`SCPC_USB_OSC_DIS]
		|| usb_reg[`SCPC_USB_BIAS_DIS];

	// Power and clock source control
	// Core regulator state follows the strap pin continuously
	// No extra stage here, so outputs move the cycle after a
	// write lands
	always_comb begin
		power_o.core_regulator_enable =
			!sync2_reg.core_regulator_enable_strap_n; // R01
		power_o.core_voltage_select = ldo_reg[`SCPC_LDO_VSEL]; // R01
		power_o.usb_regulator_enable = ref_reg
			? ldo_reg[`SCPC_LDO_USB_EN] : 1'b1; // R03
		power_o.ref_from_pin = ref_reg; // R10
		// Oscillator may stop only when it is not the system source
		power_o.usb_osc_enable = !ref_reg || !osc_off_req; // R09
		power_o.rtc_run = sync2_reg.rtc_osc_on; // R11
	end

	// Narrow access mode per space
	// Reserved code reads as word access rather than a guessed lane
	assign width_o.extmem = narrow_mode(ext_reg); // R04
	assign width_o.usb    = narrow_mode(usb_reg); // R04

	// Pulls collapse to bus holders while core power is down
	// Inhibit bit high turns its pull off; reset leaves all on
	// The holders themselves sit in the pad ring
	always_comb begin
		for (int k = 0; k < 7; k++) begin
			pull_enable_o[k*16 +: 16] = sync2_reg.core_pwr_good
				? ~pull_reg[k] : 16'h0000; // R06
		end
	end
	assign bus_hold_o = !sync2_reg.core_pwr_good; // R06

	assign slew_slow_o = slew_reg[`SCPC_SLEW_SLOW]; // R07
	// Gate bit set stops the clock, so firmware can probe one at a time
	// Clocks run after reset; boot firmware gates them as it goes
	assign periph_clk_en_o = ~{pcg2_reg, pcg1_reg}; // R14
	assign idle_req_o      = idle_reg; // R15
	// Selected resets held while the soft reset counter runs
	// Firmware loads the mask first, then the count; the mask
	// alone never asserts a reset
	assign periph_rst_o = prst_reg & {16{scnt_reg != 16'h0000}}; // R13

endmodule

// *** verification/scpc_checker.sv ***
`include "scpc_regs.svh"
// ****************************************
// Port-level checks of the control block
// ****************************************
module scpc_checker
	import scpc_pkg::*;
	#(
	parameter int ADR_W     = 17,
	parameter int BOOT_CAPT = 10
	) (
	input wire logic               clk_sys,
	input wire logic               srst,
	input wire logic               wb_cyc_i,
	input wire logic               wb_stb_i,
	input wire logic               wb_we_i,
	input wire logic [ADR_W-1:0]   wb_adr_i,
	input wire logic [3:0]         wb_sel_i,
	input wire logic [31:0]        wb_dat_i,
	input wire logic [31:0]        wb_dat_o,
	input wire logic               wb_ack_o,
	input wire scpc_pins_s         pins_i,
	input wire logic               rtc_req_o,
	input wire logic               rtc_ack_i,
	input wire logic [15:0]        rtc_rdata_i,
	input wire scpc_power_s        power_o,
	input wire scpc_width_s        width_o,
	input wire logic [111:0]       pull_enable_o,
	input wire logic               bus_hold_o,
	input wire logic               slew_slow_o,
	input wire logic [31:0]        periph_clk_en_o,
	input wire logic [15:0]        idle_req_o,
	input wire logic [15:0]        periph_rst_o
	);
	logic [5:0]  up_reg;
	logic [5:0]  up_next;
	logic [14:0] idx;
	logic        wr_hit;
	logic        in_rtc;
	// Edges since reset release; saturates so late checks stay armed
	always_comb begin
		up_next = (up_reg == 6'h3F) ? up_reg : up_reg + 6'h01;
		if (srst) up_next = 6'h00;
	end
	always_ff @(posedge clk_sys) begin
		up_reg <= up_next;
	end
	// Full-word write accepted at this edge
	assign idx    = wb_adr_i[ADR_W-1:2];
	assign wr_hit = wb_ack_o && wb_we_i && (wb_sel_i[1:0] == 2'h3);
	assign in_rtc = idx >= `SCPC_IDX_RTC_LO && idx <= `SCPC_IDX_RTC_HI;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	property p_ack_local;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !rtc_req_o |=> wb_ack_o;
	endproperty
	a_ack_local: assert property (p_ack_local) else $error("no ack");
	property p_ack_drop;
		wb_ack_o && !rtc_req_o |=> !wb_ack_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack held");
	property p_core_reg;
		$stable(pins_i.core_regulator_enable_strap_n) [*3] |->
		power_o.core_regulator_enable == !pins_i.core_regulator_enable_strap_n;
	endproperty
	a_core_reg: assert property (p_core_reg) else $error("core reg");
	property p_vsel;
		wr_hit && idx == `SCPC_IDX_LDO |=>
		power_o.core_voltage_select == $past(wb_dat_i[1]);
	endproperty
	a_vsel: assert property (p_vsel) else $error("vsel");
	property p_usb_follow;
		wr_hit && idx == `SCPC_IDX_LDO && power_o.ref_from_pin |=>
		power_o.usb_regulator_enable == $past(wb_dat_i[0]);
	endproperty
	a_usb_follow: assert property (p_usb_follow) else $error("usb reg");
	property p_usb_forced;
		!power_o.ref_from_pin |->
		power_o.usb_regulator_enable && power_o.usb_osc_enable;
	endproperty
	a_usb_forced: assert property (p_usb_forced) else $error("forced");
	property p_ref_hold;
		up_reg >= BOOT_CAPT + 3 |-> $stable(power_o.ref_from_pin);
	endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("ref moved");
	property p_rtc_gate;
		wb_cyc_i && wb_stb_i && in_rtc |-> rtc_req_o == power_o.rtc_run;
	endproperty
	a_rtc_gate: assert property (p_rtc_gate) else $error("rtc gate");
	property p_pull_off;
		bus_hold_o |-> pull_enable_o == '0;
	endproperty
	a_pull_off: assert property (p_pull_off) else $error("pulls on");
	property p_slew;
		wr_hit && idx == `SCPC_IDX_SLEW |=> slew_slow_o == $past(wb_dat_i[0]);
	endproperty
	a_slew: assert property (p_slew) else $error("slew");
	property p_gate;
		wr_hit && idx == `SCPC_IDX_PCG1 |=>
		periph_clk_en_o[15:0] == ~$past(wb_dat_i[15:0]);
	endproperty
	a_gate: assert property (p_gate) else $error("clock gate");
	// Main scenarios reached
	c_rtc: cover property (rtc_req_o && rtc_ack_i);
	c_hold: cover property (bus_hold_o);
	c_ldo: cover property (wr_hit && idx == `SCPC_IDX_LDO
		&& power_o.ref_from_pin);
endmodule

// *** verification/scpc_top_test.sv ***
`include "scpc_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
// ****************************************
// Self-checking bench of the control block
// ****************************************
module scpc_top_test;
	import scpc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic          clk_sys, srst, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [16:0]   wb_adr_i;
	logic [3:0]    wb_sel_i;
	logic [31:0]   wb_dat_i, wb_dat_o, periph_clk_en_o;
	logic          wb_ack_o, rtc_req_o, rtc_ack_i, bus_hold_o, slew_slow_o;
	logic [15:0]   rtc_rdata_i, idle_req_o, periph_rst_o, q, d;
	scpc_pins_s    pins_i;
	scpc_power_s   power_o;
	scpc_width_s   width_o;
	logic [111:0]  pull_enable_o;
	logic [5:0]    bt;
	logic [14:0]   pidx [7] = '{`SCPC_IDX_PULL1, `SCPC_IDX_PULL2, `SCPC_IDX_PULL3,
		`SCPC_IDX_PULL4, `SCPC_IDX_PULL5, `SCPC_IDX_PULL6, `SCPC_IDX_PULL7};
	int            miscompares, n_tests, k;
	scpc_top u_scpc_top (.*);
	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Far-side answer, one cycle after each forwarded request
	always @(posedge clk_sys) rtc_ack_i <= rtc_req_o && !rtc_ack_i;
	function automatic logic [1:0] bm(input logic [1:0] f);
		return (f == 2'h3) ? 2'h0 : f; // Reserved code reads as word access
	endfunction
	task automatic print_verdict();
		$display("tests=%0d miscompares=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Classic cycle; waits bounded, returns settled after the ack edge
	task automatic wb(input logic w, input logic [14:0] i, input logic [15:0] dd,
		input logic [3:0] s, output logic [15:0] r);
		int n;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {i, 2'h0};
		wb_sel_i <= s;
		wb_dat_i <= {16'h0000, dd};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		r = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			print_verdict();
		end
		@(negedge clk_sys);
	endtask
	task automatic wr(input logic [14:0] i, input logic [15:0] dd);
		logic [15:0] r;
		wb(1'b1, i, dd, 4'hF, r);
	endtask
	task automatic rd(input logic [14:0] i, output logic [15:0] r);
		wb(1'b0, i, 16'h0000, 4'hF, r);
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Straps are set while reset is held, then captured after release
	task automatic do_reset(input logic sn, input logic rf, input logic [5:0] b);
		@(posedge clk_sys);
		srst   <= 1'b1;
		pins_i <= {sn, rf, 1'b1, 1'b1, b};
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		tick(16);
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		print_verdict();
	end
	// Main sequence
	initial begin
		{srst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
		{wb_adr_i, wb_sel_i, wb_dat_i, pins_i} = '0;
		void'($urandom(59951));
		rtc_rdata_i = $urandom;
		bt = $urandom;
		do_reset(1'b0, 1'b0, bt);
		rd(`SCPC_IDX_LDO, q);
		`CHK("ldo", 16'h0000, q);
		`CHK("vsel", 1'b0, power_o.core_voltage_select);
		`CHK("core_en", 1'b1, power_o.core_regulator_enable);
		`CHK("usb_osc", 2'h3, {power_o.usb_osc_enable, power_o.ref_from_pin ^ 1'b1});
		`CHK("width", 4'h0, width_o);
		`CHK("pulls", {112{1'b1}}, pull_enable_o);
		wr(`SCPC_IDX_BOOT, ~{10'h000, bt});
		rd(`SCPC_IDX_BOOT, q);
		`CHK("boot", {10'h000, bt}, q);
		rd(`SCPC_IDX_USB, q);
		`CHK("usb_rst", 16'h0030, q);
		wr(`SCPC_IDX_LDO, 16'h0002);
		`CHK("vsel", 1'b1, power_o.core_voltage_select);
		`CHK("usb_reg", 1'b1, power_o.usb_regulator_enable);
		for (int t = 0; t < 6; t++) begin
			d = $urandom;
			k = $urandom % 7;
			wr(`SCPC_IDX_PCG1, d);
			`CHK("gate1", ~d, periph_clk_en_o[15:0]);
			wr(`SCPC_IDX_PCG2, ~d);
			`CHK("gate2", d, periph_clk_en_o[31:16]);
			wr(pidx[k], d);
			`CHK("pull", ~d, pull_enable_o[k*16 +: 16]);
			wr(`SCPC_IDX_SLEW, d);
			`CHK("slew", d[0], slew_slow_o);
			wr(`SCPC_IDX_EXT, d);
			`CHK("ext_w", bm(d[1:0]), width_o.extmem);
			wr(`SCPC_IDX_USB, ~d);
			`CHK("usb_w", bm(~d[1:0]), width_o.usb);
			`CHK("osc_on", 1'b1, power_o.usb_osc_enable);
		end
		`CHK("src_kept", 1'b0, power_o.ref_from_pin);
		wb(1'b1, `SCPC_IDX_PCG1, ~d, 4'h1, q);
		`CHK("part", ~d, periph_clk_en_o[15:0]);
		wr(15'h0100, 16'hFFFF);
		rd(15'h0100, q);
		`CHK("unmap", 16'h0000, q);
		wr(`SCPC_IDX_PRST, d);
		wr(`SCPC_IDX_SRCNT, 16'h0040);
		`CHK("rst_on", d, periph_rst_o);
		tick(80);
		`CHK("rst_off", 16'h0000, periph_rst_o);
		wr(`SCPC_IDX_IDLE, d);
		`CHK("idle", d, idle_req_o);
		rd(`SCPC_IDX_RTC_LO + 15'($urandom % 128), q);
		`CHK("rtc_rd", rtc_rdata_i, q);
		@(posedge clk_sys) pins_i.rtc_osc_on <= 1'b0;
		tick(4);
		rd(`SCPC_IDX_RTC_HI, q);
		`CHK("rtc_off", 17'h00000, {power_o.rtc_run, q});
		@(posedge clk_sys) pins_i.core_pwr_good <= 1'b0;
		tick(4);
		`CHK("hold", 113'h1, {pull_enable_o, bus_hold_o});
		bt = ~bt;
		do_reset(1'b1, 1'b1, bt);
		`CHK("ref1", 4'h1, power_o[5:2]);
		`CHK("osc_off", 1'b0, power_o.usb_osc_enable);
		rd(`SCPC_IDX_BOOT, q);
		`CHK("boot2", {10'h000, bt}, q);
		wr(`SCPC_IDX_LDO, 16'h0001);
		`CHK("usb_reg1", 1'b1, power_o.usb_regulator_enable);
		wr(`SCPC_IDX_USB, 16'h0000);
		`CHK("osc_en", 1'b1, power_o.usb_osc_enable);
		wr(`SCPC_IDX_USB, 16'h0010);
		`CHK("osc_dis", 1'b0, power_o.usb_osc_enable);
		wr(`SCPC_IDX_USB, 16'h0020);
		`CHK("bias_dis", 1'b0, power_o.usb_osc_enable);
		@(posedge clk_sys) pins_i.ref_sel <= 1'b0;
		tick(6);
		`CHK("ref_kept", 1'b1, power_o.ref_from_pin);
		print_verdict();
	end
endmodule
// Checker beside the design top
bind scpc_top scpc_checker #(.ADR_W(ADR_W), .BOOT_CAPT(BOOT_CAPT)) u_scpc_checker (.*);
